//--- dv/rxa_lane_tx.sv
// Far-end lane transmitter model: code groups and framing bytes.
// Assumes the aligner's clock and one command per cycle from the bench.
`timescale 1ns/10ps
`default_nettype none
module rxa_lane_tx (
  // Clock, reset, commands
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic [1:0] kind,
  input  wire logic [7:0] bin,
  input  wire logic       lsb_first,
  // Lane side
  output logic            cg_valid,
  output logic [9:0]      cg_data,
  output logic            cg_invalid,
  output logic            fr_valid,
  output logic [7:0]      fr_byte
);
  logic       rd_q;
  logic       rd_d;
  logic [9:0] cg_d;
  logic [7:0] fb_d;
  ////////////////////////////////////////
  // Idle lines show the inverse of the last value, never a stale copy
  always_comb begin
    rd_d = rd_q;
    cg_d = ~cg_data;
    fb_d = ~fr_byte;
    if (kind == 2'd1) begin
      cg_d = rd_q ? 10'h283 : 10'h17c;
      rd_d = ~rd_q;
    end
    if (kind == 2'd2) begin
      cg_d = 10'h000;
    end
    for (int i = 0; i < 8; i++) begin
      if (kind == 2'd3) begin
        fb_d[i] = lsb_first ? bin[7-i] : bin[i];
      end
    end
  end
  // Register the lane outputs; bytes always arrive whole, no bit slip is ever asked
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rd_q       <= 1'b0;
      cg_valid   <= 1'b0;
      cg_invalid <= 1'b0;
      fr_valid   <= 1'b0;
      cg_data    <= 10'h000;
      fr_byte    <= 8'h00;
    end else begin
      rd_q       <= rd_d;
      cg_valid   <= (kind == 2'd1) || (kind == 2'd2);
      cg_invalid <= kind == 2'd2;
      fr_valid   <= kind == 2'd3;
      cg_data    <= cg_d;
      fr_byte    <= fb_d;
    end
  end
endmodule
`default_nettype wire

//--- dv/rxa_sync_aligner_tb.sv
// Self-checking bench for the receive sync and frame aligner.
// Assumes the design's register map and a far-end model on the lane.
`timescale 1ns/10ps
`default_nettype none
module rxa_sync_aligner_tb;
  logic        clk;
  logic        rst_b;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        rm_change;
  logic        frame_pattern_size_sel;
  logic [1:0]  kind;
  logic [7:0]  bin;
  logic        lsb_first;
  logic        cg_valid;
  logic [9:0]  cg_data;
  logic        cg_invalid;
  logic        fr_valid;
  logic [7:0]  fr_byte;
  logic        lane_sync;
  logic        frame_lock;
  logic        deser_en;
  logic [1:0]  data_width;
  logic        dout_valid;
  logic [31:0] dout;
  logic        irq;
  logic [31:0] d;
  logic [31:0] last_dout;
  int          dv_cnt = 0;
  int          fail_count;
  int          checked;
  ////////////////////////////////////////
  // Short frame counts keep the run brief
  rxa_sync_aligner #(.FRAME_CYC(64), .MISS_CYC(128)) rxa_sync_aligner_inst (
    .clk(clk), .rst_b(rst_b), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cg_valid(cg_valid),
    .cg_data(cg_data), .cg_invalid(cg_invalid), .rm_change(rm_change),
    .fr_valid(fr_valid), .fr_byte(fr_byte), .frame_pattern_size_sel(frame_pattern_size_sel),
    .lane_sync(lane_sync), .frame_lock(frame_lock), .deser_en(deser_en),
    .data_width(data_width), .dout_valid(dout_valid), .dout(dout), .irq(irq));
  // Bench plays the fabric: one lane, no idle generation or lane alignment asked
  rxa_lane_tx rxa_lane_tx_inst (
    .clk(clk), .rst_b(rst_b), .kind(kind), .bin(bin), .lsb_first(lsb_first),
    .cg_valid(cg_valid), .cg_data(cg_data), .cg_invalid(cg_invalid),
    .fr_valid(fr_valid), .fr_byte(fr_byte));
  // Clock and watchdog
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  initial begin
    repeat (40000) @(posedge clk);
    fail_count++;
    end_of_test();
  end
  // Count aligned words
  always @(posedge clk) begin
    if (dout_valid === 1'b1) begin
      dv_cnt    <= dv_cnt + 1;
      last_dout <= dout;
    end
  end
  ////////////////////////////////////////
  task automatic end_of_test();
    if (fail_count == 0 && checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= v;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr    <= 1'b0;
  endtask
  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd   <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic step(input logic [1:0] k, input int n);
    repeat (n) begin
      @(posedge clk);
      kind <= k;
    end
  endtask
  task automatic fb(input logic [7:0] b);
    @(posedge clk);
    kind <= 2'd3;
    bin  <= b;
  endtask
  task automatic rm();
    @(posedge clk);
    rm_change <= 1'b1;
    @(posedge clk);
    rm_change <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (6) @(posedge clk);
    rst_b <= 1'b1;
  endtask
  // One framing case: reset, configure, header, then data packing
  task automatic frow(input logic [1:0] rate, input logic sel, input logic rev,
                      input int n, input logic lk, input int cnt, input logic [31:0] ex);
    logic [31:0] m;
    int          base;
    m = (rate == 2'd0) ? 32'hff : (rate == 2'd1) ? 32'hffff : 32'hffffffff;
    do_reset();
    wr(8'h00, {28'h0, rev, rate, 1'b1});
    frame_pattern_size_sel <= sel;
    lsb_first <= rev;
    step(2'd0, 2);
    chk(data_width, (rate == 2'd0) ? 2'd0 : (rate == 2'd1) ? 2'd1 : 2'd3);
    chk(deser_en, rate != 2'd0);
    fb(8'h00);
    repeat (n) fb(8'hf6);
    repeat (n) fb(8'h28);
    step(2'd0, 3);
    chk(frame_lock, lk);
    rd(8'h08);
    chk(d[2], lk);
    if (lk) begin
      base = dv_cnt;
      fb(8'h11);
      fb(8'h22);
      fb(8'h33);
      fb(8'h44);
      // Word counter sits one flop behind the design's strobe
      step(2'd0, 4);
      chk(dv_cnt - base, cnt);
      chk(last_dout & m, ex);
    end
  endtask
  ////////////////////////////////////////
  initial begin
    rst_b = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    rm_change = 1'b0;
    frame_pattern_size_sel = 1'b0;
    kind = 2'd0;
    bin = 8'h00;
    lsb_first = 1'b0;
    fail_count = 0;
    checked = 0;
    do_reset();
    chk({deser_en, data_width}, 3'h5);
    chk({lane_sync, frame_lock, irq, dout_valid}, 4'h0);
    wr(8'h04, 32'hffffffff);
    for (int a = 0; a < 20; a += 4) begin
      rd(a[7:0]);
      chk(d, 32'h0);
    end
    // Two changes in one sequence flag, a comma between does not
    rm();
    // Comma must reach the design before the next change
    step(2'd1, 1);
    step(2'd0, 2);
    rm();
    step(2'd0, 2);
    rd(8'h08);
    chk(d[4], 1'b0);
    rm();
    rm();
    step(2'd0, 2);
    rd(8'h08);
    chk(d[4], 1'b1);
    do_reset();
    // An invalid group restarts the comma count
    wr(8'h0c, 32'h1f);
    step(2'd1, 100);
    step(2'd2, 1);
    step(2'd1, 126);
    step(2'd0, 3);
    chk(lane_sync, 1'b0);
    step(2'd1, 1);
    step(2'd0, 3);
    chk({lane_sync, irq}, 2'h3);
    rd(8'h08);
    chk(d, 32'h1);
    wr(8'h08, 32'h1);
    step(2'd0, 1);
    chk(irq, 1'b0);
    wr(8'h0c, 32'h0);
    // Errors spaced by 255 good groups are forgiven, 254 are not
    repeat (3) begin
      step(2'd2, 1);
      step(2'd1, 255);
    end
    step(2'd2, 1);
    step(2'd1, 254);
    step(2'd2, 1);
    step(2'd0, 3);
    chk(lane_sync, 1'b1);
    step(2'd1, 254);
    step(2'd2, 1);
    step(2'd0, 3);
    chk({lane_sync, irq}, 2'h0);
    rd(8'h08);
    chk(d, 32'h2);
    wr(8'h0c, 32'h2);
    step(2'd0, 1);
    chk(irq, 1'b1);
    wr(8'h08, 32'h2);
    step(2'd0, 1);
    chk(irq, 1'b0);
    step(2'd1, 126);
    step(2'd0, 3);
    chk(lane_sync, 1'b0);
    step(2'd1, 1);
    step(2'd0, 3);
    chk(lane_sync, 1'b1);
    @(posedge clk);
    rst_b <= 1'b0;
    @(posedge clk);
    #1;
    chk(lane_sync, 1'b0);
    // Framing cases: rate, size select, bit order, header run
    frow(2'd0, 1'b0, 1'b1, 12, 1'b1, 4, 32'h44);
    frow(2'd1, 1'b1, 1'b0, 48, 1'b1, 2, 32'h3344);
    frow(2'd0, 1'b1, 1'b0, 1, 1'b0, 0, 32'h0);
    frow(2'd2, 1'b0, 1'b0, 1, 1'b0, 0, 32'h0);
    frow(2'd2, 1'b0, 1'b0, 2, 1'b1, 1, 32'h11223344);
    // Lock holds until the header has been missing long enough
    repeat (120) fb(8'h00);
    step(2'd0, 3);
    chk(frame_lock, 1'b1);
    repeat (10) fb(8'h00);
    step(2'd0, 3);
    chk(frame_lock, 1'b0);
    rd(8'h08);
    chk(d[3], 1'b1);
    step(2'd1, 130);
    step(2'd0, 3);
    chk(lane_sync, 1'b0);
    // Four-byte pattern four bits off the byte grid locks at offset four
    fb(8'h0f);
    fb(8'h6f);
    fb(8'h62);
    fb(8'h82);
    fb(8'h80);
    step(2'd0, 3);
    rd(8'h04);
    chk(d, 32'h12);
    end_of_test();
  end
endmodule
`default_nettype wire

//--- include/rxa_params.svh
// Constants for the receive sync and frame aligner: offsets, fields, resets, counts.
// Assumes inclusion by bare name from the design file.
`ifndef RXA_PARAMS_SVH
`define RXA_PARAMS_SVH
// Register offsets (byte addresses)
`define RXA_OFF_CTRL      8'h00
`define RXA_OFF_STATUS    8'h04
`define RXA_OFF_INT_STAT  8'h08
`define RXA_OFF_INT_MASK  8'h0c
// Control fields
`define RXA_CTRL_MODE     0
`define RXA_CTRL_RATE_LO  1
`define RXA_CTRL_RATE_HI  2
`define RXA_CTRL_BITREV   3
`define RXA_CTRL_RST      4'h0
// Status fields
`define RXA_ST_SYNC       0
`define RXA_ST_FLOCK      1
`define RXA_ST_OFF_LO     2
`define RXA_ST_OFF_HI     4
// Interrupt bits
`define RXA_IRQ_SYNC_UP   0
`define RXA_IRQ_SYNC_DN   1
`define RXA_IRQ_FR_UP     2
`define RXA_IRQ_FR_DN     3
`define RXA_IRQ_RM_MULTI  4
`define RXA_IRQ_W         5
// Code groups and framing bytes
`define RXA_COMMA_NEG     10'h17c
`define RXA_COMMA_POS     10'h283
`define RXA_FR_FIRST      8'hf6
`define RXA_FR_SECOND     8'h28
// Counts
`define RXA_LOCK_COMMAS   7'd127
`define RXA_GOOD_SPAN     8'd255
`define RXA_LOSS_ERRS     2'd3
`define RXA_FRAME_US      125
`define RXA_CLK_MHZ       125
`endif

//--- include/rxa_pkg.sv
// Types for the receive sync and frame aligner.
// Uses nothing from rxa_params.svh.
package rxa_pkg;
  typedef enum logic [0:0] {
    RXA_HUNT = 1'b0,
    RXA_LOCK = 1'b1
  } rxa_sync_st_t;
  typedef enum logic [1:0] {
    RXA_RATE_LOW  = 2'b00,
    RXA_RATE_MID  = 2'b01,
    RXA_RATE_HIGH = 2'b10
  } rxa_rate_t;
endpackage

//--- src/rxa_sync_aligner.sv
// Receive lane sync state machine and optical-carrier frame aligner, with register port.
// Assumes code groups, framing bytes and fabric controls all arrive on clk.
`include "rxa_params.svh"
`timescale 1ns/10ps
`default_nettype none
module rxa_sync_aligner #(
  parameter int FRAME_CYC = `RXA_FRAME_US * `RXA_CLK_MHZ,
  parameter int MISS_CYC  = 2 * FRAME_CYC
) (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Register port
  input  wire logic [7:0]  reg_addr,
  input  wire logic [31:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic [31:0]      reg_rdata,
  // Packet mode code groups from the lane
  input  wire logic        cg_valid,
  input  wire logic [9:0]  cg_data,
  input  wire logic        cg_invalid,
  input  wire logic        rm_change,
  // Framing mode byte stream
  input  wire logic        fr_valid,
  input  wire logic [7:0]  fr_byte,
  input  wire logic        frame_pattern_size_sel,
  // Outputs
  output logic             lane_sync,
  output logic             frame_lock,
  output logic             deser_en,
  output logic [1:0]       data_width,
  output logic             dout_valid,
  output logic [31:0]      dout,
  output logic             irq
);
  ////////////////////////////////////////////////////////////////////////////////
  // Helpers
  function automatic logic is_comma(input logic [9:0] cg);
    is_comma = (cg == `RXA_COMMA_NEG) || (cg == `RXA_COMMA_POS);
  endfunction
  function automatic logic [7:0] rev8(input logic [7:0] b);
    for (int i = 0; i < 8; i++) begin
      rev8[i] = b[7-i];
    end
  endfunction
  localparam logic [15:0] PAT16 = {`RXA_FR_FIRST, `RXA_FR_SECOND};
  localparam logic [31:0] PAT32 = {`RXA_FR_FIRST, `RXA_FR_FIRST, `RXA_FR_SECOND, `RXA_FR_SECOND};
  localparam logic [15:0] MISS_W = 16'(MISS_CYC);
  ////////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [3:0]  ctrl_q, ctrl_d;
  logic [4:0]  ist_q, ist_d, imask_q, imask_d, ev;
  logic [31:0] rdata_q, rdata_d;
  logic        irq_q, irq_d;
  logic        mode_fr;
  rxa_pkg::rxa_rate_t rate;
  assign mode_fr = ctrl_q[`RXA_CTRL_MODE];
  assign rate    = rxa_pkg::rxa_rate_t'(ctrl_q[`RXA_CTRL_RATE_HI:`RXA_CTRL_RATE_LO]);
  ////////////////////////////////////////////////////////////////////////////////
  // Packet mode sync state machine; one per lane, nothing shared across lanes
  rxa_pkg::rxa_sync_st_t st_q, st_d;
  logic [6:0] comma_q, comma_d;
  logic [7:0] good_q, good_d;
  logic [1:0] err_q, err_d;
  logic       rm_seen_q, rm_seen_d;
  always_comb begin
    st_d      = st_q;
    comma_d   = comma_q;
    good_d    = good_q;
    err_d     = err_q;
    rm_seen_d = rm_seen_q;
    if (mode_fr) begin
      st_d    = rxa_pkg::RXA_HUNT;
      comma_d = 7'h00;
    end else if (cg_valid) begin
      case (st_q)
        rxa_pkg::RXA_HUNT: begin
          if (cg_invalid) begin
            comma_d = 7'h00;
          end else if (is_comma(cg_data)) begin
            comma_d = comma_q + 7'h01;
            if (comma_d == `RXA_LOCK_COMMAS) begin
              st_d   = rxa_pkg::RXA_LOCK;
              good_d = 8'h00;
              err_d  = 2'h0;
            end
          end
        end
        default: begin
          if (cg_invalid) begin
            // Long clean span forgives earlier errors
            err_d  = (good_q == `RXA_GOOD_SPAN) ? 2'h1 : err_q + 2'h1;
            good_d = 8'h00;
            if (err_d == `RXA_LOSS_ERRS) begin
              st_d    = rxa_pkg::RXA_HUNT;
              comma_d = 7'h00;
              err_d   = 2'h0;
            end
          end else if (good_q != `RXA_GOOD_SPAN) begin
            good_d = good_q + 8'h01;
          end
        end
      endcase
    end
    // A comma opens a new compensation sequence; count changes within it
    if (cg_valid && is_comma(cg_data)) begin
      rm_seen_d = 1'b0;
    end
    if (rm_change) begin
      rm_seen_d = 1'b1;
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      st_q      <= rxa_pkg::RXA_HUNT;
      comma_q   <= 7'h00;
      good_q    <= 8'h00;
      err_q     <= 2'h0;
      rm_seen_q <= 1'b0;
    end else begin
      st_q      <= st_d;
      comma_q   <= comma_d;
      good_q    <= good_d;
      err_q     <= err_d;
      rm_seen_q <= rm_seen_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Framing mode automatic aligner: search eight bit offsets in a 40-bit history
  logic [39:0] hist_q, hist_d;
  logic [2:0]  off_q, off_d;
  logic        flock_q, flock_d;
  logic [15:0] gap_q, gap_d;
  logic [1:0]  beat_q, beat_d;
  logic [31:0] dout_q, dout_d;
  logic        dv_q, dv_d;
  logic        use32, hit;
  logic [2:0]  hit_off;
  logic [7:0]  in_b, al_b;
  logic [1:0]  last_beat;
  // Highest rate has no two-byte choice
  assign use32 = (rate == rxa_pkg::RXA_RATE_HIGH) || frame_pattern_size_sel;
  // Receive bit reversal restores most significant bit first order
  assign in_b  = ctrl_q[`RXA_CTRL_BITREV] ? rev8(fr_byte) : fr_byte;
  always_comb begin
    hit     = 1'b0;
    hit_off = 3'h0;
    for (int k = 7; k >= 0; k--) begin
      if (use32 ? (hist_d[k +: 32] == PAT32) : (hist_d[k +: 16] == PAT16)) begin
        hit     = 1'b1;
        hit_off = 3'(k);
      end
    end
  end
  assign al_b      = hist_d[off_d +: 8];
  assign last_beat = (rate == rxa_pkg::RXA_RATE_LOW) ? 2'd0 :
                     (rate == rxa_pkg::RXA_RATE_MID) ? 2'd1 : 2'd3;
  always_comb begin
    hist_d  = hist_q;
    off_d   = off_q;
    flock_d = flock_q;
    gap_d   = gap_q;
    beat_d  = beat_q;
    dout_d  = dout_q;
    dv_d    = 1'b0;
    if (!mode_fr) begin
      flock_d = 1'b0;
      beat_d  = 2'd0;
    end else if (fr_valid) begin
      hist_d = {hist_q[31:0], in_b};
      // Header runs 12, 48 or 96 of each byte; any inner match re-aligns harmlessly
      if (hit) begin
        off_d   = hit_off;
        flock_d = 1'b1;
        gap_d   = 16'h0000;
        beat_d  = 2'd0;
      end else if (gap_q != MISS_W) begin
        gap_d = gap_q + 16'h0001;
      end else begin
        flock_d = 1'b0;
      end
      if (flock_d && !(hit && !flock_q)) begin
        dout_d = {dout_q[23:0], al_b};
        beat_d = (beat_q == last_beat) ? 2'd0 : beat_q + 2'd1;
        dv_d   = (beat_q == last_beat);
      end
    end
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hist_q  <= 40'h0;
      off_q   <= 3'h0;
      flock_q <= 1'b0;
      gap_q   <= 16'h0000;
      beat_q  <= 2'd0;
      dout_q  <= 32'h0;
      dv_q    <= 1'b0;
    end else begin
      hist_q  <= hist_d;
      off_q   <= off_d;
      flock_q <= flock_d;
      gap_q   <= gap_d;
      beat_q  <= beat_d;
      dout_q  <= dout_d;
      dv_q    <= dv_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Register port and interrupts; a new event beats a same-cycle clear
  always_comb begin
    ev = '0;
    ev[`RXA_IRQ_SYNC_UP]  = (st_d == rxa_pkg::RXA_LOCK) && (st_q == rxa_pkg::RXA_HUNT);
    ev[`RXA_IRQ_SYNC_DN]  = (st_d == rxa_pkg::RXA_HUNT) && (st_q == rxa_pkg::RXA_LOCK);
    ev[`RXA_IRQ_FR_UP]    = flock_d && !flock_q;
    ev[`RXA_IRQ_FR_DN]    = !flock_d && flock_q;
    ev[`RXA_IRQ_RM_MULTI] = rm_change && rm_seen_q;
    ctrl_d  = ctrl_q;
    imask_d = imask_q;
    ist_d   = ist_q;
    rdata_d = 32'h0;
    if (reg_wr) begin
      if (reg_addr == `RXA_OFF_CTRL) begin
        ctrl_d = reg_wdata[3:0];
      end else if (reg_addr == `RXA_OFF_INT_STAT) begin
        ist_d = ist_q & ~reg_wdata[4:0];
      end else if (reg_addr == `RXA_OFF_INT_MASK) begin
        imask_d = reg_wdata[4:0];
      end
    end
    ist_d = ist_d | ev;
    if (reg_rd) begin
      if (reg_addr == `RXA_OFF_CTRL) begin
        rdata_d = {28'h0, ctrl_q};
      end else if (reg_addr == `RXA_OFF_STATUS) begin
        rdata_d = {27'h0, off_q, flock_q, st_q == rxa_pkg::RXA_LOCK};
      end else if (reg_addr == `RXA_OFF_INT_STAT) begin
        rdata_d = {27'h0, ist_q};
      end else if (reg_addr == `RXA_OFF_INT_MASK) begin
        rdata_d = {27'h0, imask_q};
      end
    end
    irq_d = |(ist_d & imask_d);
  end
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q  <= `RXA_CTRL_RST;
      ist_q   <= '0;
      imask_q <= '0;
      rdata_q <= 32'h0;
      irq_q   <= 1'b0;
    end else begin
      ctrl_q  <= ctrl_d;
      ist_q   <= ist_d;
      imask_q <= imask_d;
      rdata_q <= rdata_d;
      irq_q   <= irq_d;
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Output flops; deserializer enable and width follow the mode and, in framing mode, the rate
  logic       sync_q, deser_q;
  logic [1:0] width_q;
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      sync_q  <= 1'b0;
      deser_q <= 1'b1;
      width_q <= 2'd1;
    end else begin
      sync_q  <= (st_d == rxa_pkg::RXA_LOCK);
      deser_q <= !mode_fr || (rate != rxa_pkg::RXA_RATE_LOW);
      width_q <= mode_fr ? last_beat : 2'd1;
    end
  end
  assign lane_sync  = sync_q;
  assign frame_lock = flock_q;
  assign deser_en   = deser_q;
  assign data_width = width_q;
  assign dout_valid = dv_q;
  assign dout       = dout_q;
  assign reg_rdata  = rdata_q;
  assign irq        = irq_q;
  ////////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  a_lock_needs_commas: assert property ($rose(lane_sync) |-> $past(comma_q) == 7'd126)
    else $error("sync rose without 127 commas");
  a_invalid_clears: assert property (st_q == rxa_pkg::RXA_HUNT && !mode_fr && cg_valid
    && cg_invalid |=> comma_q == 7'h00)
    else $error("invalid group did not clear comma count");
  a_comma_forms: assert property (st_q == rxa_pkg::RXA_HUNT && !mode_fr && cg_valid
    && !cg_invalid && cg_data == 10'h283 && comma_q < 7'd126 |=> comma_q == $past(comma_q) + 7'h01)
    else $error("positive comma not counted");
  a_loss_third_err: assert property (st_q == rxa_pkg::RXA_LOCK && !mode_fr && cg_valid
    && cg_invalid && err_q == 2'h2 && good_q != 8'd255 |=> !lane_sync && comma_q == 7'h00)
    else $error("third close invalid kept sync");
  a_span_forgives: assert property (st_q == rxa_pkg::RXA_LOCK && !mode_fr && cg_valid
    && cg_invalid && good_q == 8'd255 |=> lane_sync && err_q == 2'h1)
    else $error("clean span did not forgive errors");
  a_reset_low: assert property ($rose(rst_b) |-> !lane_sync && !frame_lock)
    else $error("flags not low after reset");
  a_fr_no_sync: assert property (mode_fr |=> st_q == rxa_pkg::RXA_HUNT)
    else $error("sync machine active in framing mode");
  a_deser_pkt: assert property (!mode_fr |=> deser_en)
    else $error("deserializer off in packet mode");
  a_high_uses32: assert property (rate == rxa_pkg::RXA_RATE_HIGH |-> use32)
    else $error("two-byte pattern at highest rate");
  a_lock_on_hit: assert property (mode_fr && fr_valid && hit |=> frame_lock && off_q == $past(hit_off))
    else $error("pattern hit did not lock");
  a_low_width: assert property (mode_fr && rate == rxa_pkg::RXA_RATE_LOW |=> data_width == 2'd0)
    else $error("low rate width wrong");
  a_multi_event: assert property (rm_change && rm_seen_q |=> ist_q[`RXA_IRQ_RM_MULTI])
    else $error("second change in sequence not flagged");
  c_sync_up: cover property ($rose(lane_sync));
  c_sync_down: cover property ($fell(lane_sync));
  c_frame_lock: cover property ($rose(frame_lock) ##[1:40] dout_valid);
  c_irq: cover property ($rose(irq));
endmodule
`default_nettype wire
